// ===== dcc_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH
`define DCC_OFS_BYTE_COUNT 8'h80
`define DCC_OFS_PCI_ADDR 8'h84
`define DCC_OFS_SDRAM_ADDR 8'h88
`define DCC_OFS_NEXT_PTR 8'h8c
`define DCC_OFS_CONTROL 8'h90
`define DCC_OFS_DAC_ADDR 8'h94
`define DCC_OFS_IRQ_MASK 8'h98
`define DCC_CTL_ENABLE 0
`define DCC_CTL_XFER_DONE 2
`define DCC_CTL_ERROR 3
`define DCC_CTL_INIT_DESC 4
`define DCC_CTL_RDTYPE_LO 5
`define DCC_CTL_CHAIN_DONE 7
`define DCC_CTL_PRESCALE_LO 8
`define DCC_CTL_PCI_LEN 15
`define DCC_CTL_SDRAM_LEN_LO 16
`define DCC_BC_COUNT_HI 23
`define DCC_BC_GAP_LO 24
`define DCC_BC_DIR 30
`define DCC_BC_EOC 31
`define DCC_SDA_DAC_SEL 31
`define DCC_PTR_LO 4
`define DCC_PTR_HI 27
`define DCC_PCI_CMD_MR 4'h6
`define DCC_PCI_CMD_MRL 4'he
`define DCC_PCI_CMD_MRM 4'hc
`define DCC_PRESCALE_BASE 4
`define DCC_RST_WORD 32'h0000_0000
`endif

// ===== dcc_pkg.sv
// Types shared by the descriptor chaining block
package dcc_pkg;
  typedef enum logic [2:0] {
    DCC_IDLE = 3'b001,
    DCC_FETCH = 3'b010,
    DCC_XFER = 3'b100
  } dcc_state_e;

  typedef struct packed {
    dcc_state_e state;
    logic en;
    logic xdone;
    logic err;
    logic cdone;
    logic init_desc;
    logic [1:0] rdtype;
    logic [1:0] prescale;
    logic pci_len;
    logic [2:0] sdram_len;
    logic [31:0] bc;
    logic [31:0] pci;
    logic [31:0] sdram;
    logic [23:0] ptr;
    logic [31:0] dac;
    logic mask;
    logic [1:0] widx;
    logic fetch_req;
    logic [31:0] fetch_addr;
    logic [3:0] pci_cmd;
    logic permit;
    logic irq;
    logic waitreq;
    logic [31:0] rdata;
  } dcc_state_s;

  typedef struct packed {
    logic busy;
    logic [4:0] pre;
    logic [5:0] cnt;
  } dcc_gap_s;
endpackage

// ===== dcc_burst_gap.sv
// Interburst wait timer: count times (4 << prescale) cycles after each burst
`timescale 1ns/1ps
`include "dcc_params.svh"
module dcc_burst_gap
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_start,
  input wire logic [1:0] i_prescale,
  input wire logic [5:0] i_count,
  // Status
  output logic o_busy
);
  dcc_gap_s r;
  dcc_gap_s n;
  logic [4:0] pre_max;

  always_comb
  begin
    n = r;
    pre_max = 5'(`DCC_PRESCALE_BASE << i_prescale) - 5'h01;
    if (i_start)
    begin
      n.busy = (i_count != 6'h00);
      n.cnt = i_count;
      n.pre = 5'h00;
    end
    else if (r.busy)
    begin
      if (r.pre == pre_max)
      begin
        n.pre = 5'h00;
        n.cnt = r.cnt - 6'h01;
        n.busy = (r.cnt != 6'h01);
      end
      else
      begin
        n.pre = r.pre + 5'h01;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      r <= '0;
    else
      r <= n;
  end

  assign o_busy = r.busy;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_gap_len;
    i_start && i_count == 6'h01 && i_prescale == 2'b00
    ##1 !i_start [*5] |-> $past(o_busy, 1) && $past(o_busy, 4) && !o_busy;
  endproperty
  a_gap_len: assert property (p_gap_len)
    else $error("Interburst wait length wrong");
endmodule

// ===== dcc_channel.sv
// DMA channel descriptor chaining and control with Avalon-MM registers
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "dcc_params.svh"
module dcc_channel
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Descriptor fetch from SDRAM
  output logic o_fetch_req,
  output logic [31:0] o_fetch_addr,
  input wire logic i_fetch_valid,
  input wire logic [31:0] i_fetch_data,
  // Transfer engine
  output logic o_xfer_active,
  output logic o_dir_sdram_to_pci,
  output logic [31:0] o_pci_addr,
  output logic [27:0] o_sdram_addr,
  output logic [31:0] o_dac_addr,
  output logic [3:0] o_pci_read_cmd,
  output logic o_pci_burst_16,
  output logic [2:0] o_sdram_burst_code,
  output logic o_burst_permit,
  input wire logic i_burst_end,
  input wire logic i_xfer_ack,
  input wire logic [6:0] i_xfer_bytes,
  // Error events
  input wire logic i_pci_master_abort,
  input wire logic i_pci_target_abort,
  input wire logic i_pci_parity_err,
  input wire logic i_sdram_parity_err,
  // Processor interrupt
  output logic o_irq
);
  dcc_state_s r;
  dcc_state_s n;
  logic gap_busy;
  logic bus_go;
  logic any_err;
  logic [23:0] cnt_next;

  function automatic logic [3:0] read_cmd(input logic [1:0] t);
    case (t)
      2'b00: read_cmd = `DCC_PCI_CMD_MR;
      2'b01: read_cmd = `DCC_PCI_CMD_MRL;
      default: read_cmd = `DCC_PCI_CMD_MRM;
    endcase
  endfunction

  function automatic logic [31:0] ctl_word(input dcc_state_s s);
    ctl_word = '0;
    ctl_word[`DCC_CTL_ENABLE] = s.en;
    ctl_word[`DCC_CTL_XFER_DONE] = s.xdone;
    ctl_word[`DCC_CTL_ERROR] = s.err;
    ctl_word[`DCC_CTL_INIT_DESC] = s.init_desc;
    ctl_word[`DCC_CTL_RDTYPE_LO+:2] = s.rdtype;
    ctl_word[`DCC_CTL_CHAIN_DONE] = s.cdone;
    ctl_word[`DCC_CTL_PRESCALE_LO+:2] = s.prescale;
    ctl_word[`DCC_CTL_PCI_LEN] = s.pci_len;
    ctl_word[`DCC_CTL_SDRAM_LEN_LO+:3] = s.sdram_len;
  endfunction

  dcc_burst_gap u_gap (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_start(i_burst_end),
    .i_prescale(r.prescale),
    .i_count(r.bc[`DCC_BC_GAP_LO+:6]),
    .o_busy(gap_busy)
  );

  always_comb
  begin
    n = r;
    bus_go = (i_read || i_write) && !r.waitreq;
    any_err = i_pci_master_abort || i_pci_target_abort
      || i_pci_parity_err || i_sdram_parity_err;
    cnt_next = '0;
    n.waitreq = 1'b1;
    // Register read path, answer one cycle after the request
    if ((i_read || i_write) && r.waitreq)
    begin
      n.waitreq = 1'b0;
      case (i_address[7:2])
        6'(`DCC_OFS_BYTE_COUNT >> 2): n.rdata = r.bc;
        6'(`DCC_OFS_PCI_ADDR >> 2): n.rdata = r.pci;
        6'(`DCC_OFS_SDRAM_ADDR >> 2): n.rdata = r.sdram;
        6'(`DCC_OFS_NEXT_PTR >> 2): n.rdata = {4'h0, r.ptr, 4'h0};
        6'(`DCC_OFS_CONTROL >> 2): n.rdata = ctl_word(r);
        6'(`DCC_OFS_DAC_ADDR >> 2): n.rdata = r.dac;
        6'(`DCC_OFS_IRQ_MASK >> 2): n.rdata = {31'h0, r.mask};
        default: n.rdata = `DCC_RST_WORD;
      endcase
    end
    // Register writes take effect at the accepting edge
    if (bus_go && i_write)
    begin
      case (i_address[7:2])
        6'(`DCC_OFS_BYTE_COUNT >> 2): n.bc = i_writedata;
        6'(`DCC_OFS_PCI_ADDR >> 2): n.pci = i_writedata;
        6'(`DCC_OFS_SDRAM_ADDR >> 2): n.sdram = i_writedata;
        6'(`DCC_OFS_NEXT_PTR >> 2):
          n.ptr = i_writedata[`DCC_PTR_HI:`DCC_PTR_LO];
        6'(`DCC_OFS_DAC_ADDR >> 2): n.dac = i_writedata;
        6'(`DCC_OFS_IRQ_MASK >> 2): n.mask = i_writedata[0];
        6'(`DCC_OFS_CONTROL >> 2):
        begin
          n.init_desc = i_writedata[`DCC_CTL_INIT_DESC];
          n.rdtype = i_writedata[`DCC_CTL_RDTYPE_LO+:2];
          n.prescale = i_writedata[`DCC_CTL_PRESCALE_LO+:2];
          n.pci_len = i_writedata[`DCC_CTL_PCI_LEN];
          n.sdram_len = i_writedata[`DCC_CTL_SDRAM_LEN_LO+:3];
          if (i_writedata[`DCC_CTL_XFER_DONE])
            n.xdone = 1'b0;
          if (i_writedata[`DCC_CTL_ERROR])
            n.err = 1'b0;
          if (i_writedata[`DCC_CTL_CHAIN_DONE])
            n.cdone = 1'b0;
          n.en = i_writedata[`DCC_CTL_ENABLE];
          if (!i_writedata[`DCC_CTL_ENABLE])
          begin
            n.state = DCC_IDLE;
          end
          else if (!r.en)
          begin
            n.widx = 2'b00;
            if (i_writedata[`DCC_CTL_INIT_DESC])
              n.state = DCC_XFER;
            else
              n.state = DCC_FETCH;
          end
        end
        default:
        begin
        end
      endcase
    end
    // Channel sequencing; hardware sets win over software clears
    case (r.state)
      DCC_IDLE:
      begin
      end
      DCC_FETCH:
      begin
        if (i_fetch_valid)
        begin
          case (r.widx)
            2'b00: n.bc = i_fetch_data;
            2'b01: n.pci = i_fetch_data;
            2'b10: n.sdram = i_fetch_data;
            default:
            begin
              if (r.sdram[`DCC_SDA_DAC_SEL])
                n.dac = i_fetch_data;
              else
                n.ptr = i_fetch_data[`DCC_PTR_HI:`DCC_PTR_LO];
              n.state = DCC_XFER;
            end
          endcase
          n.widx = r.widx + 2'b01;
        end
      end
      DCC_XFER:
      begin
        if (i_xfer_ack)
        begin
          if (r.bc[`DCC_BC_COUNT_HI:0] > 24'(i_xfer_bytes))
            cnt_next = r.bc[`DCC_BC_COUNT_HI:0] - 24'(i_xfer_bytes);
          n.bc[`DCC_BC_COUNT_HI:0] = cnt_next;
          if (cnt_next == 24'h000000)
          begin
            n.xdone = 1'b1;
            if (r.bc[`DCC_BC_EOC])
            begin
              n.cdone = 1'b1;
              n.en = 1'b0;
              n.dac = '0;
              n.state = DCC_IDLE;
            end
            else
            begin
              n.widx = 2'b00;
              n.state = DCC_FETCH;
            end
          end
        end
      end
      default:
        n.state = DCC_IDLE;
    endcase
    if (any_err && r.state != DCC_IDLE)
    begin
      n.err = 1'b1;
      n.cdone = 1'b1;
      n.en = 1'b0;
      n.dac = '0;
      n.state = DCC_IDLE;
    end
    n.fetch_req = (n.state == DCC_FETCH);
    n.fetch_addr = {4'h0, n.ptr, n.widx, 2'b00};
    n.pci_cmd = read_cmd(n.rdtype);
    n.permit = (n.state == DCC_XFER) && !gap_busy;
    n.irq = n.cdone && n.mask;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r <= '0;
      r.state <= DCC_IDLE;
      r.waitreq <= 1'b1;
      r.pci_cmd <= `DCC_PCI_CMD_MR;
    end
    else
    begin
      r <= n;
    end
  end

  assign o_readdata = r.rdata;
  assign o_waitrequest = r.waitreq;
  assign o_fetch_req = r.fetch_req;
  assign o_fetch_addr = r.fetch_addr;
  assign o_xfer_active = r.state[2];
  assign o_dir_sdram_to_pci = r.bc[`DCC_BC_DIR];
  assign o_pci_addr = r.pci;
  assign o_sdram_addr = r.sdram[27:0];
  assign o_dac_addr = r.dac;
  assign o_pci_read_cmd = r.pci_cmd;
  assign o_pci_burst_16 = r.pci_len;
  assign o_sdram_burst_code = r.sdram_len;
  assign o_burst_permit = r.permit;
  assign o_irq = r.irq;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_ptr_read;
    i_read && r.waitreq && i_address == `DCC_OFS_NEXT_PTR;
  endsequence

  property p_ptr_zero;
    s_ptr_read |=> o_readdata[3:0] == 4'h0 && o_readdata[31:28] == 4'h0;
  endproperty
  a_ptr_zero: assert property (p_ptr_zero)
    else $error("Pointer reserved bits not zero");

  property p_en_clears;
    $rose(r.cdone) |-> !r.en && r.dac == 32'h0;
  endproperty
  a_en_clears: assert property (p_en_clears)
    else $error("Enable or upper address left set at chain done");

  property p_err_halts;
    $rose(r.err) |-> r.state == DCC_IDLE && r.cdone;
  endproperty
  a_err_halts: assert property (p_err_halts)
    else $error("Channel not halted on error");

  sequence s_last_beat;
    r.state == DCC_XFER && i_xfer_ack && !any_err
      && r.bc[23:0] <= 24'(i_xfer_bytes);
  endsequence

  property p_next_fetch;
    s_last_beat and !r.bc[31] |=> r.state == DCC_FETCH && o_fetch_req
      && r.xdone;
  endproperty
  a_next_fetch: assert property (p_next_fetch)
    else $error("Next descriptor not fetched");

  property p_start;
    !r.en && r.state == DCC_IDLE && i_write && !r.waitreq
      && i_address == `DCC_OFS_CONTROL && i_writedata[0]
      |=> r.state == ($past(i_writedata[4]) ? DCC_XFER : DCC_FETCH) && r.en;
  endproperty
  a_start: assert property (p_start)
    else $error("Channel did not start as selected");

  property p_cmd;
    o_pci_read_cmd == (r.rdtype == 2'b00 ? `DCC_PCI_CMD_MR
      : r.rdtype == 2'b01 ? `DCC_PCI_CMD_MRL : `DCC_PCI_CMD_MRM);
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("PCI read command mismatch");

  property p_irq;
    o_irq == (r.cdone && r.mask);
  endproperty
  a_irq: assert property (p_irq)
    else $error("Chain interrupt missing");

  property p_fetch_addr;
    o_fetch_req |-> o_fetch_addr[3:0] == {r.widx, 2'b00}
      && o_fetch_addr[27:4] == r.ptr;
  endproperty
  a_fetch_addr: assert property (p_fetch_addr)
    else $error("Descriptor word address wrong");
endmodule

// ===== dcc_sdram_model.sv
// SDRAM partner model answering descriptor word fetches
`timescale 1ns/1ps
module dcc_sdram_model
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Fetch request
  input wire logic i_fetch_req,
  input wire logic [31:0] i_fetch_addr,
  input wire logic i_slow,
  // Fetch answer
  output logic o_fetch_valid,
  output logic [31:0] o_fetch_data
);
  logic [31:0] mem [0:63];
  logic [1:0] dly;
  // One word per valid at the requested offset
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_fetch_valid <= 1'b0;
      o_fetch_data <= 32'h0;
      dly <= 2'h0;
    end
    else if (!o_fetch_valid && i_fetch_req && (dly == 2'h3 || !i_slow))
    begin
      o_fetch_valid <= 1'b1;
      o_fetch_data <= mem[i_fetch_addr[7:2]];
      dly <= 2'h0;
    end
    else
    begin
      // Data not valid: scramble so a stale word never looks good
      o_fetch_valid <= 1'b0;
      o_fetch_data <= ~o_fetch_data;
      dly <= (i_fetch_req && !o_fetch_valid) ? dly + 2'h1 : 2'h0;
    end
  end
endmodule

// ===== tb.sv
// Testbench for the descriptor chaining channel
`timescale 1ns/1ps
`include "dcc_params.svh"
module tb;
  logic clk;
  logic rst_n;
  logic [7:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wreq;
  logic freq;
  logic [31:0] faddr;
  logic fval;
  logic [31:0] fdata;
  logic xact;
  logic dir;
  logic [27:0] sda;
  logic [31:0] dac;
  logic [31:0] pcia;
  logic [3:0] cmd;
  logic b16;
  logic [2:0] sbc;
  logic permit;
  logic irq;
  logic [5:0] ev;
  logic [6:0] bytes;
  logic slow;
  logic [31:0] q;
  int err_count;
  int checks_done;
  int n;
  logic [3:0] cmd_tab [0:3];

  always #25 clk = ~clk;

  dcc_channel DUT (.i_mclk(clk), .i_rst_n(rst_n), .i_address(addr),
    .i_read(rd), .i_write(wr), .i_writedata(wdata), .o_readdata(rdata),
    .o_waitrequest(wreq), .o_fetch_req(freq), .o_fetch_addr(faddr),
    .i_fetch_valid(fval), .i_fetch_data(fdata), .o_xfer_active(xact),
    .o_dir_sdram_to_pci(dir), .o_pci_addr(pcia), .o_sdram_addr(sda),
    .o_dac_addr(dac), .o_pci_read_cmd(cmd), .o_pci_burst_16(b16),
    .o_sdram_burst_code(sbc), .o_burst_permit(permit),
    .i_burst_end(ev[1]), .i_xfer_ack(ev[0]), .i_xfer_bytes(bytes),
    .i_pci_master_abort(ev[2]), .i_pci_target_abort(ev[3]),
    .i_pci_parity_err(ev[4]), .i_sdram_parity_err(ev[5]), .o_irq(irq));

  dcc_sdram_model sdram (.i_mclk(clk), .i_rst_n(rst_n),
    .i_fetch_req(freq), .i_fetch_addr(faddr), .i_slow(slow),
    .o_fetch_valid(fval), .o_fetch_data(fdata));

  task automatic report_and_stop;
    if (err_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timeout;
    err_count++;
    report_and_stop;
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk);
      if (wreq === 1'b0)
        break;
    end
    if (k == 50)
      timeout;
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic wait_act(input logic v);
    int k;
    for (k = 0; k < 300 && xact !== v; k++)
      @(negedge clk);
    if (k == 300)
      timeout;
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= 6'h0;
  endtask

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    addr = 8'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    ev = 6'h0;
    bytes = 7'h8;
    slow = 1'b1;
    err_count = 0;
    checks_done = 0;
    cmd_tab = '{4'h6, 4'he, 4'hc, 4'hc};
    sdram.mem[4] = 32'h0000_0008;
    sdram.mem[5] = 32'h0000_1000;
    sdram.mem[6] = 32'h0000_2000;
    sdram.mem[7] = 32'h0000_0020;
    sdram.mem[8] = 32'h8100_0004;
    sdram.mem[9] = 32'h0000_5000;
    sdram.mem[10] = 32'h0000_6000;
    sdram.mem[11] = 32'h0000_0000;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(`DCC_OFS_CONTROL, 32'h0);
    bus(1'b1, `DCC_OFS_NEXT_PTR, 32'hffff_ffff);
    rdchk(`DCC_OFS_NEXT_PTR, 32'h0fff_fff0);
    bus(1'b1, `DCC_OFS_CONTROL, 32'hffff_fffe);
    rdchk(`DCC_OFS_CONTROL, 32'h0007_8370);
    chk({28'h0, b16, sbc}, 32'hf);
    rdchk(8'h9c, 32'h0);
    for (n = 0; n < 4; n++)
    begin
      bus(1'b1, `DCC_OFS_CONTROL, (n << 5) | (n << 16) | (n[0] << 15));
      repeat (2) @(negedge clk);
      chk({28'h0, cmd}, {28'h0, cmd_tab[n]});
      chk({28'h0, b16, sbc}, {28'h0, n[0], n[2:0]});
    end
    // Two descriptor chain fetched from memory
    bus(1'b1, `DCC_OFS_DAC_ADDR, 32'h55);
    bus(1'b1, `DCC_OFS_IRQ_MASK, 32'h1);
    bus(1'b1, `DCC_OFS_NEXT_PTR, 32'h10);
    bus(1'b1, `DCC_OFS_CONTROL, 32'h1);
    wait_act(1'b1);
    chk(pcia, 32'h1000);
    chk({4'h0, sda}, 32'h2000);
    chk(dac, 32'h55);
    chk({31'h0, dir}, 32'h0);
    slow <= 1'b0;
    pulse(0);
    wait_act(1'b0);
    wait_act(1'b1);
    chk(pcia, 32'h5000);
    chk({4'h0, sda}, 32'h6000);
    rdchk(`DCC_OFS_CONTROL, 32'h5);
    chk({31'h0, permit}, 32'h1);
    bytes <= 7'h4;
    pulse(1);
    for (n = 0; n < 100 && permit !== 1'b0; n++)
      @(negedge clk);
    if (n == 100)
      timeout;
    for (n = 0; n < 100 && permit !== 1'b1; n++)
      @(negedge clk);
    if (n == 100)
      timeout;
    chk(n, 32'd4);
    pulse(0);
    wait_act(1'b0);
    rdchk(`DCC_OFS_CONTROL, 32'h84);
    chk({31'h0, irq}, 32'h1);
    rdchk(`DCC_OFS_DAC_ADDR, 32'h0);
    bus(1'b1, `DCC_OFS_CONTROL, 32'h84);
    rdchk(`DCC_OFS_CONTROL, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Preloaded descriptor, each error source halts it
    bus(1'b1, `DCC_OFS_IRQ_MASK, 32'h0);
    for (n = 0; n < 4; n++)
    begin
      bus(1'b1, `DCC_OFS_BYTE_COUNT, 32'hc000_0010);
      bus(1'b1, `DCC_OFS_PCI_ADDR, 32'h3000 + n);
      bus(1'b1, `DCC_OFS_DAC_ADDR, 32'h77 + n);
      bus(1'b1, `DCC_OFS_CONTROL, 32'h11);
      wait_act(1'b1);
      chk(pcia, 32'h3000 + n);
      chk(dac, 32'h77 + n);
      chk({31'h0, dir}, 32'h1);
      pulse(n + 2);
      @(negedge clk);
      chk({31'h0, xact}, 32'h0);
      rdchk(`DCC_OFS_CONTROL, 32'h98);
      chk({31'h0, irq}, 32'h0);
      rdchk(`DCC_OFS_DAC_ADDR, 32'h0);
      bus(1'b1, `DCC_OFS_CONTROL, 32'h8c);
    end
    report_and_stop;
  end
endmodule
